//--- design/lin_port_cfg.svh
`ifndef LIN_PORT_CFG_SVH
`define LIN_PORT_CFG_SVH
// frame layout: one read/write bit, address, optional turnaround, data
`define ADDR_W      4
`define DATA_W      8
`define DEPTH       16
`define CNT_W       4
`define ADDR_LAST   4'h3
`define DATA_LAST   4'h7
`define TURN_LAST   4'h1
`define RW_READ     1'b1
`define CHANNELS    4
// command register defaults and placement of control words
`define REG_DEFAULT 8'h00
`define CTRL_ADDR   4'h0
`define MISC_ADDR   4'h1
`define SHUTOFF_BIT 0
`define INVERT_BIT  1
`define ALL_CH      4'hF
`endif

//--- design/lin_port_pkg.sv
`include "lin_port_cfg.svh"
package lin_port_pkg;
  // frame collected on the serial clock and handed to the system clock
  typedef struct packed {
    logic                 wr;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   data;
  } frame_type;

  typedef enum logic [2:0] {
    PH_RW,
    PH_ADDR,
    PH_TURN,
    PH_DATA,
    PH_DONE
  } phase_type;
endpackage : lin_port_pkg

//--- design/cmd_reg_mem.sv
`timescale 1ns/10ps
`include "lin_port_cfg.svh"
module cmd_reg_mem (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_b_i,
  input  wire logic                clear_i,
  input  wire logic                wr_en_i,
  input  wire logic [`ADDR_W-1:0]  wr_addr_i,
  input  wire logic [`DATA_W-1:0]  wr_data_i,
  input  wire logic                rd_en_i,
  input  wire logic [`ADDR_W-1:0]  rd_addr_i,
  output logic      [`DATA_W-1:0]  rd_data_o,
  output logic      [`DATA_W-1:0]  ctrl_word_o,
  output logic      [`DATA_W-1:0]  misc_word_o
);
  logic [`DATA_W-1:0] mem_reg [`DEPTH];

  // storage; clear wins over a write so a held reset really restores defaults
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `DEPTH; i++) mem_reg[i] <= `REG_DEFAULT;
    end else if (clear_i) begin
      for (int i = 0; i < `DEPTH; i++) mem_reg[i] <= `REG_DEFAULT;
    end else if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read port, holds until the next read
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= `REG_DEFAULT;
    end else if (rd_en_i) begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

  assign ctrl_word_o = mem_reg[`CTRL_ADDR];
  assign misc_word_o = mem_reg[`MISC_ADDR];
endmodule : cmd_reg_mem

//--- design/lin_serial_port.sv
`timescale 1ns/10ps
`include "lin_port_cfg.svh"
// Notes on behaviour
// (R1) serial port works only in processor mode; straps act only in hardware mode
// (R2) master holds port select low for a whole transfer
// (R3) port select idles high, so an undriven select means deselected
// (R4) serial input captured on each rising serial clock edge while selected
// (R5) serial output changes only on falling serial clock edges
// (R6) master sends read/write bit, address, then data for writes
// (R7) a read shifts the addressed command register out serially
// (R8) serial output driven only while read data returns, released afterwards
// (R9) register reset low in processor mode restores all register defaults
// (R10) hardware mode: register reset pin selects recovered clock inversion
// (R11) hardware mode: serial clock pin high shuts off all receivers
// (R12) hardware mode: serial clock pin low keeps all receivers running
// (R13) hardware mode: port select high selects single-rail on every channel
// (R14) processor mode: rail bit 1 selects single-rail and enables violation output
// (R15) frame widths, order and turnaround kept as constants; msb first
module lin_serial_port (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  host_mode_i,
  input  wire logic                  port_select_n_i,
  input  wire logic                  sclk_i,
  input  wire logic                  serial_in_i,
  input  wire logic                  register_reset_n_i,
  output logic                       serial_out_o,
  output logic                       serial_out_oe_o,
  output logic                       receiver_shutoff_o,
  output logic                       recovered_clock_invert_o,
  output logic [`CHANNELS-1:0]       rail_format_select_o,
  output logic [`CHANNELS-1:0]       line_violation_flag_o
);
  lin_port_pkg::phase_type phase_reg;
  lin_port_pkg::frame_type shift_reg;
  lin_port_pkg::frame_type hold_reg;
  logic [`CNT_W-1:0]       cnt_reg;
  logic                    rd_tgl_reg;
  logic                    wr_tgl_reg;
  logic                    host_l1_reg;
  logic                    host_l2_reg;
  logic [`DATA_W-1:0]      out_shift_reg;
  logic                    loaded_reg;
  logic                    link_rst_n;
  logic [3:0]              pin_s1_reg;
  logic [3:0]              pin_s2_reg;
  logic [2:0]              rd_sync_reg;
  logic [2:0]              wr_sync_reg;
  logic                    host_s;
  logic                    cs_s;
  logic                    sclk_s;
  logic                    register_reset_n_s;
  logic                    rd_pulse;
  logic                    wr_pulse;
  logic                    mem_we;
  logic                    mem_clear;
  logic [`DATA_W-1:0]      rd_data;
  logic [`DATA_W-1:0]      ctrl_word;
  logic [`DATA_W-1:0]      misc_word;

  function automatic logic tgl_edge(input logic [2:0] s);
    tgl_edge = s[2] ^ s[1];
  endfunction : tgl_edge

  // a high (or floating, pulled-up) select holds the link logic idle
  assign link_rst_n = rst_b_i & ~port_select_n_i; // [R3] [R2]

  // mode strap seen on the serial clock, for gating the frame engine
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      host_l1_reg <= 1'b0;
      host_l2_reg <= 1'b0;
    end else begin
      host_l1_reg <= host_mode_i;
      host_l2_reg <= host_l1_reg;
    end
  end

  // frame engine on rising serial clock edges
  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase_reg <= lin_port_pkg::PH_RW;
      cnt_reg   <= '0;
      shift_reg <= '0;
    end else begin
      case (phase_reg)
        lin_port_pkg::PH_RW: begin
          if (host_l2_reg) begin // [R1]
            shift_reg.wr <= (serial_in_i != `RW_READ); // [R6] [R4]
            phase_reg    <= lin_port_pkg::PH_ADDR;
            cnt_reg      <= '0;
          end
        end
        lin_port_pkg::PH_ADDR: begin
          shift_reg.addr <= {shift_reg.addr[`ADDR_W-2:0], serial_in_i}; // [R4] [R15]
          cnt_reg        <= cnt_reg + 1'b1;
          if (cnt_reg == `ADDR_LAST) begin
            cnt_reg   <= '0;
            phase_reg <= shift_reg.wr ? lin_port_pkg::PH_DATA : lin_port_pkg::PH_TURN;
          end
        end
        lin_port_pkg::PH_TURN: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == `TURN_LAST) begin // [R15]
            cnt_reg   <= '0;
            phase_reg <= lin_port_pkg::PH_DATA;
          end
        end
        lin_port_pkg::PH_DATA: begin
          if (shift_reg.wr) begin
            shift_reg.data <= {shift_reg.data[`DATA_W-2:0], serial_in_i}; // [R4] [R6]
          end
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == `DATA_LAST) begin
            phase_reg <= lin_port_pkg::PH_DONE;
          end
        end
        lin_port_pkg::PH_DONE: phase_reg <= lin_port_pkg::PH_DONE;
        default:               phase_reg <= lin_port_pkg::PH_RW;
      endcase
    end
  end

  // hand-off words and toggles; not cleared by select so no request is lost
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_reg   <= '0;
      rd_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
    end else if (!port_select_n_i) begin
      if (phase_reg == lin_port_pkg::PH_ADDR && cnt_reg == `ADDR_LAST
          && !shift_reg.wr) begin
        hold_reg.wr   <= 1'b0;
        hold_reg.addr <= {shift_reg.addr[`ADDR_W-2:0], serial_in_i};
        rd_tgl_reg    <= ~rd_tgl_reg; // [R7]
      end
      if (phase_reg == lin_port_pkg::PH_DATA && cnt_reg == `DATA_LAST
          && shift_reg.wr) begin
        hold_reg.wr   <= 1'b1;
        hold_reg.addr <= shift_reg.addr;
        hold_reg.data <= {shift_reg.data[`DATA_W-2:0], serial_in_i};
        wr_tgl_reg    <= ~wr_tgl_reg;
      end
    end
  end

  // read data leaves on falling edges only, driven during the data phase
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0; // [R8]
      out_shift_reg   <= '0;
      loaded_reg      <= 1'b0;
    end else if (phase_reg == lin_port_pkg::PH_DATA && !shift_reg.wr) begin
      serial_out_oe_o <= 1'b1; // [R8] [R1]
      loaded_reg      <= 1'b1;
      if (!loaded_reg) begin
        serial_out_o  <= rd_data[`DATA_W-1]; // [R5] [R7] [R15]
        out_shift_reg <= {rd_data[`DATA_W-2:0], 1'b0};
      end else begin
        serial_out_o  <= out_shift_reg[`DATA_W-1]; // [R5]
        out_shift_reg <= {out_shift_reg[`DATA_W-2:0], 1'b0};
      end
    end else begin
      serial_out_oe_o <= 1'b0; // [R8]
    end
  end

  // pins and toggles into the system clock; first stage read only by the second
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_reg  <= 4'h0;
      pin_s2_reg  <= 4'h0;
      rd_sync_reg <= 3'h0;
      wr_sync_reg <= 3'h0;
    end else begin
      pin_s1_reg  <= {host_mode_i, port_select_n_i, sclk_i, register_reset_n_i};
      pin_s2_reg  <= pin_s1_reg;
      rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
    end
  end

  assign host_s    = pin_s2_reg[3];
  assign cs_s      = pin_s2_reg[2];
  assign sclk_s    = pin_s2_reg[1];
  assign register_reset_n_s    = pin_s2_reg[0];
  assign rd_pulse  = tgl_edge(rd_sync_reg);
  assign wr_pulse  = tgl_edge(wr_sync_reg);
  // register writes only in processor mode, and never while reset is held
  assign mem_we    = wr_pulse & host_s & register_reset_n_s; // [R1]
  assign mem_clear = host_s & ~register_reset_n_s; // [R9]

  cmd_reg_mem u_mem (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .clear_i     (mem_clear),
    .wr_en_i     (mem_we),
    .wr_addr_i   (hold_reg.addr),
    .wr_data_i   (hold_reg.data),
    .rd_en_i     (rd_pulse),
    .rd_addr_i   (hold_reg.addr),
    .rd_data_o   (rd_data),
    .ctrl_word_o (ctrl_word),
    .misc_word_o (misc_word)
  );

  // pin functions chosen by mode; hardware mode reads the shared pins as straps
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      receiver_shutoff_o       <= 1'b0;
      recovered_clock_invert_o <= 1'b0;
      rail_format_select_o     <= '0;
      line_violation_flag_o    <= '0;
    end else if (host_s) begin
      receiver_shutoff_o       <= misc_word[`SHUTOFF_BIT];
      recovered_clock_invert_o <= misc_word[`INVERT_BIT];
      rail_format_select_o     <= ctrl_word[`CHANNELS-1:0]; // [R14]
      line_violation_flag_o    <= ctrl_word[`CHANNELS-1:0]; // [R14]
    end else begin
      receiver_shutoff_o       <= sclk_s; // [R11] [R12]
      recovered_clock_invert_o <= register_reset_n_s; // [R10]
      rail_format_select_o     <= cs_s ? `ALL_CH : '0; // [R13]
      line_violation_flag_o    <= cs_s ? `ALL_CH : '0; // [R13]
    end
  end

  a_hw_rx_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R11]
    (!host_s && sclk_s) |=> receiver_shutoff_o)
    else $error("receiver not shut off in hardware mode");
  a_hw_rx_on: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R12]
    (!host_s && !sclk_s) |=> !receiver_shutoff_o)
    else $error("receiver shut off while pin low");
  a_hw_clk_inv: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R10]
    !host_s |=> (recovered_clock_invert_o == $past(register_reset_n_s)))
    else $error("clock invert does not follow pin");
  a_hw_rail_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R13]
    (!host_s && cs_s) |=> (rail_format_select_o == `ALL_CH && line_violation_flag_o == `ALL_CH))
    else $error("single-rail not selected by strap");
  a_rail_lcv_tie: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R14]
    host_s ##1 host_s |-> (line_violation_flag_o == $past(ctrl_word[`CHANNELS-1:0])))
    else $error("violation enable not following rail bits");
  a_register_reset_n_default: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R9]
    (host_s && !register_reset_n_s) |=> (ctrl_word == `REG_DEFAULT && misc_word == `REG_DEFAULT))
    else $error("register reset did not restore defaults");
  a_hw_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R1]
    !host_s |=> ($stable(ctrl_word) && $stable(misc_word)))
    else $error("command register changed in hardware mode");
  a_oe_read_only: assert property (@(negedge sclk_i) disable iff (!link_rst_n) // [R8]
    serial_out_oe_o |-> (!shift_reg.wr && phase_reg != lin_port_pkg::PH_RW
                         && phase_reg != lin_port_pkg::PH_ADDR))
    else $error("serial output driven outside read data");
  a_addr_capture: assert property (@(posedge sclk_i) disable iff (!link_rst_n) // [R4]
    (phase_reg == lin_port_pkg::PH_ADDR) |=> (shift_reg.addr[0] == $past(serial_in_i)))
    else $error("address bit not captured on rising edge");
endmodule : lin_serial_port

//--- tb/host_serial_model.sv
`timescale 1ns/10ps
// serial master on the far side; its clock stands still low between frames
module host_serial_model (
  input  wire logic sdo_i,
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  localparam real HALF = 62.5;
  initial begin
    sel_n_o = 1'b1; // undriven select idles high
    sclk_o  = 1'b0;
    sdi_o   = 1'b0;
  end
  // one clock period, data set up before the rise
  task tick(input logic b);
    sdi_o = b;
    #(HALF) sclk_o = 1'b1;
    #(HALF) sclk_o = 1'b0;
  endtask : tick
  // rises with select high let the mode sync settle
  task warm();
    repeat (2) tick(1'b0);
  endtask : warm
  // rw bit, address, then data or turnaround and read data
  task xfer(input logic rd, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    integer i;
    q = 8'h00;
    sel_n_o = 1'b0; // low for the whole frame
    #(HALF) tick(rd);
    for (i = 3; i >= 0; i--) tick(a[i]);
    if (rd) begin
      repeat (2) tick(~a[0]);
      for (i = 7; i >= 0; i--) begin
        sdi_o = ~sdi_o;
        #(HALF) sclk_o = 1'b1;
        q = {q[6:0], sdo_i}; // sampled at the rise after the falling update
        #(HALF) sclk_o = 1'b0;
      end
    end else begin
      for (i = 7; i >= 0; i--) tick(d[i]);
    end
    #(HALF) sel_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale value
    #(2 * HALF); // select stays high between frames so the engine resets
  endtask : xfer
  // hardware mode: the same pins as level straps
  task strap(input logic sel, input logic sck);
    sel_n_o = sel;
    sclk_o  = sck;
  endtask : strap
endmodule : host_serial_model

//--- tb/tb_top.sv
`timescale 1ns/10ps
`include "lin_port_cfg.svh"
module tb_top;
  logic       clk_sys_i, rst_b_i, host_mode_i, register_reset_n_i;
  logic       sel_n, sclk, serial_in, serial_out_o, serial_out_oe_o;
  logic       receiver_shutoff_o, recovered_clock_invert_o;
  logic [3:0] rail_format_select_o, line_violation_flag_o;
  logic [7:0] q;
  wire        sdo_line;
  int         fails, total_checks, oe_rises;
  // the wire floats unless the device drives it
  assign sdo_line = serial_out_oe_o ? serial_out_o : 1'bz;
  lin_serial_port i_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .host_mode_i(host_mode_i),
    .port_select_n_i(sel_n), .sclk_i(sclk), .serial_in_i(serial_in),
    .register_reset_n_i(register_reset_n_i), .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o), .receiver_shutoff_o(receiver_shutoff_o),
    .recovered_clock_invert_o(recovered_clock_invert_o),
    .rail_format_select_o(rail_format_select_o),
    .line_violation_flag_o(line_violation_flag_o));
  host_serial_model i_host (.sdo_i(sdo_line), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(serial_in));
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge serial_out_oe_o) oe_rises++;
  // data may move only after a falling serial edge
  always @(serial_out_o) begin
    if (serial_out_oe_o === 1'b1 && sclk === 1'b1) begin
      fails++;
      $display("[FAIL] serial_out_edge expected sclk 0 seen %b", sclk);
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wait_sys(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : wait_sys
  task t_reset();
    wait_sys(5);
    chk("rail", 8'h00, {4'h0, rail_format_select_o});
    chk("oe", 8'h00, {7'h0, serial_out_oe_o});
  endtask : t_reset
  // write, read back, boundary address, control words
  task t_write_read();
    int r0;
    r0 = oe_rises;
    i_host.xfer(1'b0, 4'h0, 8'hA5, q);
    i_host.xfer(1'b0, 4'hF, 8'hC3, q);
    i_host.xfer(1'b0, 4'h1, 8'h02, q);
    wait_sys(8);
    chk("rail", 8'h05, {4'h0, rail_format_select_o});
    chk("lcv", 8'h05, {4'h0, line_violation_flag_o});
    chk("ctl", 8'h02, {6'h0, recovered_clock_invert_o, receiver_shutoff_o});
    i_host.xfer(1'b1, 4'h0, 8'h00, q);
    chk("rd0", 8'hA5, q);
    i_host.xfer(1'b1, 4'hF, 8'h00, q);
    chk("rdF", 8'hC3, q);
    chk("oe", 8'h00, {7'h0, serial_out_oe_o});
    chk("oe_rises", 8'h02, 8'(oe_rises - r0));
  endtask : t_write_read
  // register reset clears and blocks writes
  task t_regreset();
    wait_sys(1);
    register_reset_n_i = 1'b0;
    wait_sys(6);
    chk("rail", 8'h00, {4'h0, rail_format_select_o});
    chk("inv", 8'h00, {7'h0, recovered_clock_invert_o});
    i_host.xfer(1'b0, 4'h0, 8'hA5, q);
    wait_sys(1);
    register_reset_n_i = 1'b1;
    wait_sys(6);
    i_host.xfer(1'b1, 4'h0, 8'h00, q);
    chk("rd0", 8'h00, q);
  endtask : t_regreset
  // every strap combination, then a write and a read frame that must be ignored
  task t_hw();
    int k, r0;
    wait_sys(1);
    host_mode_i = 1'b0;
    for (k = 0; k < 8; k++) begin
      i_host.strap(k[0], k[1]);
      register_reset_n_i = k[2];
      wait_sys(6);
      chk("rail", k[0] ? 8'h0F : 8'h00, {4'h0, rail_format_select_o});
      chk("lcv", k[0] ? 8'h0F : 8'h00, {4'h0, line_violation_flag_o});
      chk("shut", {7'h0, k[1]}, {7'h0, receiver_shutoff_o});
      chk("inv", {7'h0, k[2]}, {7'h0, recovered_clock_invert_o});
    end
    i_host.strap(1'b1, 1'b0);
    register_reset_n_i = 1'b1;
    r0 = oe_rises;
    i_host.xfer(1'b0, 4'h0, 8'hA5, q);
    i_host.xfer(1'b1, 4'h0, 8'h00, q);
    chk("oe_rises", 8'h00, 8'(oe_rises - r0));
    wait_sys(1);
    host_mode_i = 1'b1;
    wait_sys(6);
    i_host.warm();
    chk("rail", 8'h00, {4'h0, rail_format_select_o});
    i_host.xfer(1'b1, 4'h0, 8'h00, q);
    chk("rd0", 8'h00, q);
  endtask : t_hw
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // watchdog well past the expected run of about 24 us
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
  initial begin
    clk_sys_i = 1'b0;
    rst_b_i = 1'b0;
    host_mode_i = 1'b1;
    register_reset_n_i = 1'b1;
    fails = 0;
    total_checks = 0;
    oe_rises = 0;
    wait_sys(3);
    rst_b_i = 1'b1;
    t_reset();
    i_host.warm();
    t_write_read();
    t_regreset();
    t_hw();
    report_and_stop();
  end
endmodule : tb_top
